/* pal_pkg.sv */
// Package of register indices, reset values and field positions.
`default_nettype none
package pal_pkg;

    // -----------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // -----------------------------------------------------------------
    localparam logic [5:0] PAL_IDX_MODE_TWO = 6'h04;
    localparam logic [5:0] PAL_IDX_IRQ_CAUSE = 6'h06;
    localparam logic [5:0] PAL_IDX_IRQ_MASK = 6'h07;
    localparam logic [5:0] PAL_IDX_ALARM_CAUSE = 6'h08;
    localparam logic [5:0] PAL_IDX_ALARM_MASK = 6'h09;
    localparam logic [5:0] PAL_IDX_PERF_CAUSE = 6'h0a;
    localparam logic [5:0] PAL_IDX_PERF_MASK = 6'h0b;

    // -----------------------------------------------------------------
    // Widths, reset values and fixed bits.
    // -----------------------------------------------------------------
    localparam int PAL_AW = 8;
    localparam int PAL_PERF_W = 6;
    localparam int PAL_LAT_W = 6;
    localparam logic [7:0] PAL_RST_IRQ_MASK = 8'hff;
    localparam logic [7:0] PAL_RST_ALARM_MASK = 8'hff;
    localparam logic [5:0] PAL_RST_PERF_MASK = 6'h3f;
    localparam logic [1:0] PAL_RST_MODE = 2'h0;
    localparam logic [1:0] PAL_PERF_CAUSE_PAD = 2'h0;
    localparam logic [1:0] PAL_PERF_MASK_PAD = 2'h3;
    localparam logic [5:0] PAL_MODE_TWO_PAD = 6'h00;

    // -----------------------------------------------------------------
    // Field positions of the top-level cause and mask registers.
    // -----------------------------------------------------------------
    localparam int PAL_BIT_PLL = 7;
    localparam int PAL_BIT_OPT = 6;
    localparam int PAL_BIT_SIG = 5;
    localparam int PAL_BIT_FRAME = 4;
    localparam int PAL_BIT_ALM = 3;
    localparam int PAL_BIT_PFM = 2;
    localparam int PAL_BIT_OVF = 1;
    localparam int PAL_BIT_FIFO = 0;

    // -----------------------------------------------------------------
    // Interrupt modes; codes 2 and 3 both select clear on read.
    // -----------------------------------------------------------------
    localparam logic [1:0] PAL_MODE_LATCH = 2'h0;
    localparam logic [1:0] PAL_MODE_FOLLOW = 2'h1;

    // Tells whether a register index is decoded by the block.
    function automatic logic pal_is_mapped(input logic [5:0] idx);
        pal_is_mapped = (idx == PAL_IDX_MODE_TWO) ||
            ((idx >= PAL_IDX_IRQ_CAUSE) && (idx <= PAL_IDX_PERF_MASK));
    endfunction

endpackage
`default_nettype wire

/* pal_reg_if.sv */
// Interface between the bus slave and the register core.
`timescale 1ns/100ps
`default_nettype none
interface pal_reg_if;
    logic [5:0] idx;
    logic [7:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] rd_q;
    logic [7:0] rdata;

    // The slave decodes the bus; the core answers with read data.
    modport slv (output idx, output wdata, output wr_stb, output rd_stb,
                 output rd_q, input rdata);
    modport core (input idx, input wdata, input wr_stb, input rd_stb,
                  input rd_q, output rdata);
endinterface
`default_nettype wire

/* pal_cause_latch.sv */
// Bank of cause bits that latch and clear as the interrupt mode says.
`timescale 1ns/100ps
`default_nettype none
module pal_cause_latch #(
    parameter int W = 8
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [1:0] mode_in,
    input wire logic [W-1:0] cond_in,
    input wire logic [W-1:0] clr_in,
    output logic [W-1:0] cause_out
);
    logic [W-1:0] prev_r;
    logic [W-1:0] cause_r;
    logic [W-1:0] cause_nxt;

    // Next value; a new set always beats a clear in the same cycle.
    always_comb begin
        case (mode_in)
            pal_pkg::PAL_MODE_LATCH: begin
                cause_nxt = (cause_r & ~clr_in) | cond_in;
            end
            pal_pkg::PAL_MODE_FOLLOW: begin
                cause_nxt = cond_in;
            end
            default: begin
                // Only a fresh rise sets, so a read can clear a live cause.
                cause_nxt = (cause_r & ~clr_in) | (cond_in & ~prev_r);
            end
        endcase
    end

    // Previous condition level for edge detection.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prev_r <= '0;
        end else begin
            prev_r <= cond_in;
        end
    end

    // Cause bits.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cause_r <= '0;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    assign cause_out = cause_r;
endmodule // pal_cause_latch
`default_nettype wire

/* pal_apb_slave.sv */
// APB slave that decodes transfers for the register core.
`timescale 1ns/100ps
`default_nettype none
module pal_apb_slave (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [pal_pkg::PAL_AW-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    pal_reg_if.slv bus
);
    logic hit;
    logic [7:0] rd_q_r;

    // Word-aligned addresses inside the map are decoded.
    assign hit = (paddr_in[1:0] == 2'h0) && pal_pkg::pal_is_mapped(bus.idx);
    assign bus.idx = paddr_in[7:2];
    assign bus.wdata = pwdata_in[7:0];
    assign bus.wr_stb = psel_in && penable_in && pwrite_in && hit;
    assign bus.rd_stb = psel_in && penable_in && !pwrite_in && hit;
    assign bus.rd_q = rd_q_r;

    // Read data is captured in the setup cycle and held for the access.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_q_r <= 8'h00;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            rd_q_r <= (paddr_in[1:0] == 2'h0) &&
                pal_pkg::pal_is_mapped(paddr_in[7:2]) ? bus.rdata : 8'h00;
        end
    end

    // Zero wait states; unmapped addresses answer with an error.
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !hit;
    assign prdata_out = {24'h000000, rd_q_r};
endmodule // pal_apb_slave
`default_nettype wire

/* pal_phy_alarm_irq.sv */
// Alarm and performance interrupt cause, mask and summary logic.
`timescale 1ns/100ps
`default_nettype none
module pal_phy_alarm_irq (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [pal_pkg::PAL_AW-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic pll_unlock_in,
    input wire logic optical_alarm_pin_in,
    input wire logic signal_absent_in,
    input wire logic frame_lost_in,
    input wire logic counter_overflow_flag_in,
    input wire logic rx_fifo_overrun_in,
    input wire logic [7:0] alarm_cond_in,
    input wire logic [pal_pkg::PAL_PERF_W-1:0] perf_cond_in,
    output logic irq_out_n
);

    // -----------------------------------------------------------------
    // Bus slave
    // -----------------------------------------------------------------

    pal_reg_if bus ();

    // Decodes APB transfers into strobes for the register core.
    pal_apb_slave u_apb (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .bus(bus)
    );

    // -----------------------------------------------------------------
    // Software-written registers
    // -----------------------------------------------------------------

    logic [1:0] irq_mode_r;
    logic [7:0] phy_irq_mask_r;
    logic [7:0] alarm_cause_mask_r;
    logic [pal_pkg::PAL_PERF_W-1:0] perf_cause_mask_r;

    // Interrupt mode field of the second mode register.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_mode_r <= pal_pkg::PAL_RST_MODE;
        end else if (bus.wr_stb && (bus.idx == pal_pkg::PAL_IDX_MODE_TWO)) begin
            irq_mode_r <= bus.wdata[1:0];
        end
    end

    // Top-level mask; a one masks the cause in the same position.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phy_irq_mask_r <= pal_pkg::PAL_RST_IRQ_MASK;
        end else if (bus.wr_stb && (bus.idx == pal_pkg::PAL_IDX_IRQ_MASK)) begin
            phy_irq_mask_r <= bus.wdata;
        end
    end

    // Alarm mask; a one keeps the alarm out of the summary.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            alarm_cause_mask_r <= pal_pkg::PAL_RST_ALARM_MASK;
        end else if (bus.wr_stb &&
                     (bus.idx == pal_pkg::PAL_IDX_ALARM_MASK)) begin
            alarm_cause_mask_r <= bus.wdata;
        end
    end

    // Performance mask; only the six low bits are stored.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            perf_cause_mask_r <= pal_pkg::PAL_RST_PERF_MASK;
        end else if (bus.wr_stb &&
                     (bus.idx == pal_pkg::PAL_IDX_PERF_MASK)) begin
            perf_cause_mask_r <= bus.wdata[pal_pkg::PAL_PERF_W-1:0];
        end
    end

    // -----------------------------------------------------------------
    // Read clears
    // -----------------------------------------------------------------

    logic [7:0] top_clr;
    logic [7:0] alarm_clr;
    logic [pal_pkg::PAL_PERF_W-1:0] perf_clr;
    logic [pal_pkg::PAL_LAT_W-1:0] lat_clr;

    // Only the bits that the host actually saw are cleared.
    assign top_clr = (bus.rd_stb && (bus.idx == pal_pkg::PAL_IDX_IRQ_CAUSE)) ?
        bus.rd_q : 8'h00;
    assign alarm_clr = (bus.rd_stb &&
        (bus.idx == pal_pkg::PAL_IDX_ALARM_CAUSE)) ? bus.rd_q : 8'h00;
    assign perf_clr = (bus.rd_stb &&
        (bus.idx == pal_pkg::PAL_IDX_PERF_CAUSE)) ?
        bus.rd_q[pal_pkg::PAL_PERF_W-1:0] : 6'h00;

    // Top clear vector in the order of the latched top bits.
    assign lat_clr = {top_clr[pal_pkg::PAL_BIT_PLL],
                      top_clr[pal_pkg::PAL_BIT_OPT],
                      top_clr[pal_pkg::PAL_BIT_SIG],
                      top_clr[pal_pkg::PAL_BIT_FRAME],
                      top_clr[pal_pkg::PAL_BIT_OVF],
                      top_clr[pal_pkg::PAL_BIT_FIFO]};

    // -----------------------------------------------------------------
    // Cause banks
    // -----------------------------------------------------------------

    logic [pal_pkg::PAL_LAT_W-1:0] lat_cond;
    logic [pal_pkg::PAL_LAT_W-1:0] lat_q;
    logic [7:0] alarm_cause_q;
    logic [pal_pkg::PAL_PERF_W-1:0] perf_cause_q;

    // Directly latched top-level conditions.
    assign lat_cond = {pll_unlock_in, optical_alarm_pin_in, signal_absent_in,
                       frame_lost_in, counter_overflow_flag_in,
                       rx_fifo_overrun_in};

    // Top-level status bits obey the interrupt mode.
    pal_cause_latch #(
        .W(pal_pkg::PAL_LAT_W)
    ) u_top_lat (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .mode_in(irq_mode_r),
        .cond_in(lat_cond),
        .clr_in(lat_clr),
        .cause_out(lat_q)
    );

    // Alarm causes, latched and cleared as the interrupt mode says.
    pal_cause_latch #(
        .W(8)
    ) u_alarm_lat (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .mode_in(irq_mode_r),
        .cond_in(alarm_cond_in),
        .clr_in(alarm_clr),
        .cause_out(alarm_cause_q)
    );

    // Performance causes.
    pal_cause_latch #(
        .W(pal_pkg::PAL_PERF_W)
    ) u_perf_lat (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .mode_in(irq_mode_r),
        .cond_in(perf_cond_in),
        .clr_in(perf_clr),
        .cause_out(perf_cause_q)
    );

    // -----------------------------------------------------------------
    // Summaries and interrupt
    // -----------------------------------------------------------------

    logic alarm_summary;
    logic perf_summary;
    logic [7:0] phy_irq_cause;

    // Summaries see only causes whose mask bit is clear.
    assign alarm_summary = |(alarm_cause_q & ~alarm_cause_mask_r);
    assign perf_summary = |(perf_cause_q & ~perf_cause_mask_r);

    // Top-level cause register assembled field by field.
    always_comb begin
        phy_irq_cause = 8'h00;
        phy_irq_cause[pal_pkg::PAL_BIT_PLL] = lat_q[5];
        phy_irq_cause[pal_pkg::PAL_BIT_OPT] = lat_q[4];
        phy_irq_cause[pal_pkg::PAL_BIT_SIG] = lat_q[3];
        phy_irq_cause[pal_pkg::PAL_BIT_FRAME] = lat_q[2];
        phy_irq_cause[pal_pkg::PAL_BIT_ALM] = alarm_summary;
        phy_irq_cause[pal_pkg::PAL_BIT_PFM] = perf_summary;
        phy_irq_cause[pal_pkg::PAL_BIT_OVF] = lat_q[1];
        phy_irq_cause[pal_pkg::PAL_BIT_FIFO] = lat_q[0];
    end

    // The mask is applied on every cycle, so a change acts at once.
    assign irq_out_n = ~|(phy_irq_cause &
                          ~phy_irq_mask_r);

    // -----------------------------------------------------------------
    // Read multiplexer
    // -----------------------------------------------------------------

    // Fixed pad bits read as constants; unmapped indices read zero.
    always_comb begin
        case (bus.idx)
            pal_pkg::PAL_IDX_MODE_TWO: begin
                bus.rdata = {pal_pkg::PAL_MODE_TWO_PAD, irq_mode_r};
            end
            pal_pkg::PAL_IDX_IRQ_CAUSE: begin
                bus.rdata = phy_irq_cause;
            end
            pal_pkg::PAL_IDX_IRQ_MASK: begin
                bus.rdata = phy_irq_mask_r;
            end
            pal_pkg::PAL_IDX_ALARM_CAUSE: begin
                bus.rdata = alarm_cause_q;
            end
            pal_pkg::PAL_IDX_ALARM_MASK: begin
                bus.rdata = alarm_cause_mask_r;
            end
            pal_pkg::PAL_IDX_PERF_CAUSE: begin
                bus.rdata = {pal_pkg::PAL_PERF_CAUSE_PAD, perf_cause_q};
            end
            pal_pkg::PAL_IDX_PERF_MASK: begin
                bus.rdata = {pal_pkg::PAL_PERF_MASK_PAD,
                             perf_cause_mask_r};
            end
            default: begin
                bus.rdata = 8'h00;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------

    logic top_read;
    assign top_read = bus.rd_stb && (bus.idx == pal_pkg::PAL_IDX_IRQ_CAUSE);

    // In modes 00 and 01, overflow of a counter shows in bit one on the next edge.
    a_ovf_sets: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (counter_overflow_flag_in && !irq_mode_r[1]) |=> phy_irq_cause[1])
        else $error("counter overflow did not set cause bit");

    // In follow mode bit zero tracks FIFO overflow one edge later.
    a_fifo_sets: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (irq_mode_r == 2'h1) |=>
        (phy_irq_cause[0] == $past(rx_fifo_overrun_in)))
        else $error("fifo cause bit does not track overflow");

    // An unmasked cause drives the interrupt low.
    a_irq_active: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (phy_irq_cause[0] && !phy_irq_mask_r[0]) |-> !irq_out_n)
        else $error("unmasked cause without interrupt");

    // Writing the top mask stores the written byte.
    a_mask_write: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (bus.wr_stb && (bus.idx == pal_pkg::PAL_IDX_IRQ_MASK)) |=>
        (phy_irq_mask_r == $past(bus.wdata)))
        else $error("top mask write lost");

    // A masked optical bit never raises the interrupt on its own.
    a_opt_masked: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (phy_irq_mask_r[6] &&
         ((phy_irq_cause & ~phy_irq_mask_r & 8'hbf) == 8'h00)) |->
        irq_out_n)
        else $error("masked cause raised interrupt");

    // Masked alarms never reach the summary bit.
    a_alm_masked: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (alarm_cause_mask_r == 8'hff) |-> !phy_irq_cause[3])
        else $error("masked alarm set summary");

    // Mode 00 holds a set bit until a read takes it.
    a_mode_hold: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        ((irq_mode_r == 2'h0) && phy_irq_cause[7] && !top_read) |=>
        phy_irq_cause[7])
        else $error("latched cause lost without read");

    // Mode 01 follows the condition one edge later.
    a_mode_follow: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (irq_mode_r == 2'h1) |=>
        (phy_irq_cause[7] == $past(pll_unlock_in)))
        else $error("following cause does not track input");

    // Mode 1X clears a read bit unless a fresh rise arrives.
    a_mode_clear: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (irq_mode_r[1] && top_read && bus.rd_q[7] && !pll_unlock_in) |=>
        !phy_irq_cause[7])
        else $error("read did not clear cause");

    // In mode 00 a cause present during a clearing read survives it.
    a_set_wins: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        ((irq_mode_r == 2'h0) && top_read && frame_lost_in) |=>
        phy_irq_cause[4])
        else $error("new cause lost to read clear");

    // Fixed bits of the performance mask register read back as ones.
    a_perf_pads: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (bus.idx == pal_pkg::PAL_IDX_PERF_MASK) |->
        (bus.rdata[7:6] == 2'h3))
        else $error("performance mask pad bits wrong");

endmodule // pal_phy_alarm_irq
`default_nettype wire

/* pal_phy_alarm_irq_bench.sv */
// Self-checking bench for the alarm and performance interrupt block.
`timescale 1ns/100ps
`default_nettype none
module pal_phy_alarm_irq_bench;
    // -----------------------------------------------------------------
    // Signals and counters.
    // -----------------------------------------------------------------
    logic clk_in = 1'b0;
    logic arst_n_in, psel, penable, pwrite, pready, pslverr, irq_n, e;
    logic [7:0] paddr, top_c, alarm_c, q, b;
    logic [31:0] pwdata, prdata;
    logic [5:0] perf_c;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;

    // Device under test, with every input driven by the bench.
    pal_phy_alarm_irq u_pal_phy_alarm_irq (.clk_in(clk_in),
        .arst_n_in(arst_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .pll_unlock_in(top_c[7]), .optical_alarm_pin_in(top_c[6]),
        .signal_absent_in(top_c[5]), .frame_lost_in(top_c[4]),
        .counter_overflow_flag_in(top_c[1]),
        .rx_fifo_overrun_in(top_c[0]), .alarm_cond_in(alarm_c),
        .perf_cond_in(perf_c), .irq_out_n(irq_n));

    // Clock of 100 ns period.
    initial begin
        forever #50 clk_in = ~clk_in;
    end

    // A hang is cut short after a fixed number of cycles.
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            close_out();
        end
    end

    // -----------------------------------------------------------------
    // Bus cycles and comparisons.
    // -----------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Compares one register byte.
    task automatic chk(input string nm, input logic [7:0] x,
                       input logic [7:0] g);
        num_checks++;
        if (g !== x) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask

    // Compares the interrupt pin once the last edge has settled.
    task automatic irq_chk(input logic x);
        #1;
        num_checks++;
        if (irq_n !== x) begin
            miscompares++;
            $display("Error irq_out_n expected %b seen %b", x, irq_n);
        end
        @(posedge clk_in);
    endtask

    // One APB transfer, then one idle cycle before the next one.
    task automatic apb(input logic w, input logic [5:0] idx,
                       input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    // Reads a register and compares it.
    task automatic rd(input logic [5:0] idx, input logic [7:0] x);
        apb(1'b0, idx, 8'h00);
        chk($sformatf("register %h", idx), x, q);
    endtask

    task automatic tick();
        @(posedge clk_in);
    endtask

    // -----------------------------------------------------------------
    // Test sequence.
    // -----------------------------------------------------------------
    initial begin
        arst_n_in = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {top_c, alarm_c, perf_c} = '0;
        repeat (4) @(posedge clk_in);
        arst_n_in <= 1'b1;
        tick();
        irq_chk(1'b1);
        rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h00);
        rd(pal_pkg::PAL_IDX_IRQ_MASK, 8'hff);
        rd(pal_pkg::PAL_IDX_ALARM_CAUSE, 8'h00);
        rd(pal_pkg::PAL_IDX_ALARM_MASK, 8'hff);
        rd(pal_pkg::PAL_IDX_PERF_CAUSE, 8'h00);
        rd(pal_pkg::PAL_IDX_PERF_MASK, 8'hff);
        wr(pal_pkg::PAL_IDX_PERF_MASK, 8'h00);
        rd(pal_pkg::PAL_IDX_PERF_MASK, 8'hc0);
        wr(pal_pkg::PAL_IDX_PERF_CAUSE, 8'hff);
        rd(pal_pkg::PAL_IDX_PERF_CAUSE, 8'h00);
        wr(pal_pkg::PAL_IDX_ALARM_CAUSE, 8'hff);
        rd(pal_pkg::PAL_IDX_ALARM_CAUSE, 8'h00);
        wr(pal_pkg::PAL_IDX_ALARM_MASK, 8'h5a);
        rd(pal_pkg::PAL_IDX_ALARM_MASK, 8'h5a);
        wr(pal_pkg::PAL_IDX_ALARM_MASK, 8'hff);
        wr(pal_pkg::PAL_IDX_PERF_MASK, 8'hfe);
        apb(1'b0, 6'h3f, 8'h00);
        chk("pslverr_out", 8'h01, {7'h0, e});
        // Each top-level cause except bits two and three is latched, unmasked, read and cleared.
        for (int i = 0; i < 8; i++) begin
            if (i != 2 && i != 3) begin
                b = 8'h01 << i;
                top_c <= b;
                tick();
                top_c <= 8'h00;
                tick();
                irq_chk(1'b1);
                wr(pal_pkg::PAL_IDX_IRQ_MASK, ~b);
                irq_chk(1'b0);
                rd(pal_pkg::PAL_IDX_IRQ_CAUSE, b);
                rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h00);
                irq_chk(1'b1);
            end
        end
        // Alarm summary through its own mask and top-level bit three.
        wr(pal_pkg::PAL_IDX_IRQ_MASK, 8'hf7);
        alarm_c <= 8'h40;
        tick();
        rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h00);
        rd(pal_pkg::PAL_IDX_ALARM_CAUSE, 8'h40);
        wr(pal_pkg::PAL_IDX_ALARM_MASK, 8'hbf);
        irq_chk(1'b0);
        rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h08);
        wr(pal_pkg::PAL_IDX_IRQ_MASK, 8'hff);
        irq_chk(1'b1);
        alarm_c <= 8'h00;
        tick();
        rd(pal_pkg::PAL_IDX_ALARM_CAUSE, 8'h40);
        rd(pal_pkg::PAL_IDX_ALARM_CAUSE, 8'h00);
        // Performance summary, one cause masked and one passed.
        perf_c <= 6'h02;
        tick();
        perf_c <= 6'h00;
        rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h00);
        perf_c <= 6'h01;
        tick();
        perf_c <= 6'h00;
        wr(pal_pkg::PAL_IDX_IRQ_MASK, 8'hfb);
        irq_chk(1'b0);
        rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h04);
        rd(pal_pkg::PAL_IDX_PERF_CAUSE, 8'h03);
        rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h00);
        irq_chk(1'b1);
        // A condition still present during a clearing read sets again.
        top_c <= 8'h10;
        tick();
        rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h10);
        rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h10);
        top_c <= 8'h00;
        tick();
        rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h10);
        rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h00);
        // Follow mode: reads do not clear, the bit tracks its condition.
        wr(pal_pkg::PAL_IDX_IRQ_MASK, 8'hfe);
        wr(pal_pkg::PAL_IDX_MODE_TWO, 8'h01);
        rd(pal_pkg::PAL_IDX_MODE_TWO, 8'h01);
        top_c <= 8'h01;
        tick();
        tick();
        rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h01);
        rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h01);
        irq_chk(1'b0);
        top_c <= 8'h00;
        tick();
        tick();
        rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h00);
        // Clear-on-read modes, both codes, with the condition still high.
        for (int m = 2; m < 4; m++) begin
            wr(pal_pkg::PAL_IDX_MODE_TWO, 8'(m));
            top_c <= 8'h01;
            tick();
            tick();
            rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h01);
            rd(pal_pkg::PAL_IDX_IRQ_CAUSE, 8'h00);
            irq_chk(1'b1);
            top_c <= 8'h00;
            tick();
        end
        close_out();
    end
endmodule // pal_phy_alarm_irq_bench
`default_nettype wire
